/* hdl/adc_cal_params.svh */
// Constants for the calibration sequencer
`ifndef ADC_CAL_PARAMS_SVH
`define ADC_CAL_PARAMS_SVH

`define CAL_HOLD_MIN_CYC   3'd4
`define CAL_SELF_CYC       3145655
`define CAL_SYS_OFF_CYC    1052599
`define CAL_SYS_GAIN_CYC   1068813
`define CAL_ONE_OFF_CYC    2117389
`define CAL_SETTLE_CYC     4096
`define CODE_W             20
`define CODE_STEPS         1048576
`define CODE_ZERO          20'h00000
`define CODE_FULL          20'hFFFFF
`define CODE_MID           20'h80000
`define SEL_SELF           2'b00
`define SEL_SYS_OFF        2'b11
`define SEL_SYS_GAIN       2'b01
`define SEL_ONE_OFF        2'b10

`endif

/* hdl/adc_cal_pkg.sv */
// Types for the calibration sequencer
package adc_cal_pkg;
  typedef enum logic [3:0] {
    ST_IDLE   = 4'b0001,
    ST_ARMED  = 4'b0010,
    ST_CAL    = 4'b0100,
    ST_SETTLE = 4'b1000
  } calState_t;
endpackage

/* hdl/code_scaler.sv */
// Scales a raw modulator reading to the calibrated 20-bit span
`timescale 1ns/1ps
`default_nettype none
`include "adc_cal_params.svh"
module code_scaler
  import adc_cal_pkg::*;
#(
  parameter int W = 24
) (
  input  wire logic [W-1:0] rawIn,
  input  wire logic [W-1:0] zeroPt,
  input  wire logic [W-1:0] fullPt,
  input  wire logic         bipolar,
  output logic [19:0]       codeOut
);
  logic signed [W+1:0] diff;
  logic signed [W+1:0] span;
  logic signed [W+22:0] scaled;
  logic signed [W+22:0] biased;
  always_comb begin
    diff = $signed({2'b00, rawIn}) - $signed({2'b00, zeroPt});
    span = $signed({2'b00, fullPt}) - $signed({2'b00, zeroPt});
    if (span <= 0)
      span = (W+2)'(1);
    // Unipolar step is span/2^20, bipolar 2*span/2^20
    if (bipolar)
      scaled = ($signed({{21{diff[W+1]}}, diff}) * (W+23)'(`CODE_STEPS / 2))
               / $signed({{21{1'b0}}, span});
    else
      scaled = ($signed({{21{diff[W+1]}}, diff}) * (W+23)'(`CODE_STEPS))
               / $signed({{21{1'b0}}, span});
    biased = bipolar ? scaled + (W+23)'(`CODE_STEPS / 2) : scaled;
    // Saturate at both ends
    if (biased < 0)
      codeOut = `CODE_ZERO;
    else if (biased > (W+23)'(`CODE_STEPS - 1))
      codeOut = `CODE_FULL;
    else
      codeOut = biased[19:0];
  end
endmodule
`default_nettype wire

/* hdl/adc_calibration_sequencer.sv */
// Calibration sequencer for a 20-bit sigma-delta converter
`timescale 1ns/1ps
`default_nettype none
`include "adc_cal_params.svh"
module adc_calibration_sequencer
  import adc_cal_pkg::*;
#(
  parameter int RAW_W      = 24,
  parameter int SELF_CYC   = `CAL_SELF_CYC,
  parameter int SYSOFF_CYC = `CAL_SYS_OFF_CYC,
  parameter int SYSGN_CYC  = `CAL_SYS_GAIN_CYC,
  parameter int ONEOFF_CYC = `CAL_ONE_OFF_CYC,
  parameter int SETTLE_CYC = `CAL_SETTLE_CYC
) (
  input  wire logic             ref_clk,
  input  wire logic             sys_rst,
  input  wire logic             calRequest,
  input  wire logic             cal_select_a,
  input  wire logic             cal_select_b,
  input  wire logic             polarity_select,
  input  wire logic [RAW_W-1:0] rawSample,
  input  wire logic             rawValid,
  output logic                  conversion_valid_n,
  output logic [19:0]           dataCode,
  output logic                  calBusy
);
  localparam int CW = 22;

  typedef struct packed {
    calState_t        state;
    logic             reqPrev;
    logic [2:0]       highCnt;
    logic [1:0]       selLatch;
    logic [CW-1:0]    cnt;
    logic [RAW_W-1:0] zeroPt;
    logic [RAW_W-1:0] fullPt;
    logic             drdyN;
    logic [19:0]      code;
    logic             busy;
  } seqState_t;

  seqState_t s_r;
  seqState_t s_nxt;
  logic [19:0] scaled;

  // Calibration length from latched selects
  function automatic logic [CW-1:0] calLen(input logic [1:0] sel);
    case (sel)
      `SEL_SELF:     calLen = CW'(SELF_CYC);
      `SEL_SYS_OFF:  calLen = CW'(SYSOFF_CYC);
      `SEL_SYS_GAIN: calLen = CW'(SYSGN_CYC);
      default:       calLen = CW'(ONEOFF_CYC);
    endcase
  endfunction

  code_scaler #(
    .W (RAW_W)
  ) u_scaler (
    .rawIn   (rawSample),
    .zeroPt  (s_r.zeroPt),
    .fullPt  (s_r.fullPt),
    .bipolar (polarity_select),
    .codeOut (scaled)
  );

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    s_nxt = s_r;
    s_nxt.reqPrev = calRequest;
    case (s_r.state)
      ST_IDLE, ST_SETTLE: begin
        if (s_r.state == ST_SETTLE) begin
          if (s_r.cnt == CW'(1)) begin
            s_nxt.state = ST_IDLE;
            s_nxt.drdyN = 1'b0;
          end else begin
            s_nxt.cnt = s_r.cnt - CW'(1);
          end
        end else if (rawValid) begin
          s_nxt.code  = scaled;
          s_nxt.drdyN = 1'b0;
        end
        // Recalibration may preempt settling or measurement
        if (calRequest && !s_r.reqPrev) begin
          s_nxt.state    = ST_ARMED;
          s_nxt.selLatch = {cal_select_a, cal_select_b};
          s_nxt.highCnt  = 3'd1;
          s_nxt.drdyN    = 1'b1;
        end
      end
      ST_ARMED: begin
        s_nxt.drdyN = 1'b1;
        if (calRequest) begin
          if (s_r.highCnt != 3'd7)
            s_nxt.highCnt = s_r.highCnt + 3'd1;
        end else if (s_r.highCnt >= `CAL_HOLD_MIN_CYC) begin
          s_nxt.state = ST_CAL;
          s_nxt.cnt   = calLen(s_r.selLatch);
        end else begin
          // Short pulse is discarded, old result stays invalid
          s_nxt.state = ST_IDLE;
        end
      end
      ST_CAL: begin
        s_nxt.drdyN = 1'b1;
        if (rawValid)
          case (s_r.selLatch)
            `SEL_SELF, `SEL_SYS_OFF, `SEL_ONE_OFF: s_nxt.zeroPt = rawSample;
            default:                               s_nxt.fullPt = rawSample;
          endcase
        if (s_r.cnt == CW'(1)) begin
          case (s_r.selLatch)
            `SEL_SELF: begin
              // Full scale set to the zero point plus a nominal 2^20 span
              s_nxt.fullPt = s_r.zeroPt + RAW_W'(`CODE_STEPS);
              s_nxt.state  = ST_SETTLE;
              s_nxt.cnt    = CW'(SETTLE_CYC);
            end
            `SEL_SYS_GAIN: begin
              s_nxt.state = ST_IDLE;
              s_nxt.code  = `CODE_FULL;
              s_nxt.drdyN = 1'b0;
            end
            `SEL_ONE_OFF: begin
              s_nxt.fullPt = s_r.zeroPt + RAW_W'(`CODE_STEPS);
              s_nxt.state  = ST_IDLE;
              s_nxt.code   = `CODE_ZERO;
              s_nxt.drdyN  = 1'b0;
            end
            default: begin
              s_nxt.state = ST_IDLE;
              s_nxt.code  = `CODE_ZERO;
              s_nxt.drdyN = 1'b0;
            end
          endcase
        end else begin
          s_nxt.cnt = s_r.cnt - CW'(1);
        end
      end
      default: s_nxt.state = ST_IDLE;
    endcase
    // Busy registered so the output comes straight from a flop
    s_nxt.busy = (s_nxt.state == ST_ARMED) || (s_nxt.state == ST_CAL);
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      s_r.state    <= ST_IDLE;
      s_r.reqPrev  <= 1'b0;
      s_r.highCnt  <= 3'd0;
      s_r.selLatch <= 2'b00;
      s_r.cnt      <= '0;
      s_r.zeroPt   <= '0;
      s_r.fullPt   <= RAW_W'(`CODE_STEPS);
      s_r.drdyN    <= 1'b1;
      s_r.code     <= `CODE_ZERO;
      s_r.busy     <= 1'b0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign conversion_valid_n = s_r.drdyN;
  assign dataCode           = s_r.code;
  assign calBusy            = s_r.busy;
endmodule
`default_nettype wire

/* testbench/adc_cal_properties.sv */
// Checker for the calibration sequencer ports
`timescale 1ns/1ps
`default_nettype none
module adc_cal_properties #(
  parameter int SELF_CYC = 30, SYSOFF_CYC = 20, SYSGN_CYC = 24,
  parameter int ONEOFF_CYC = 40, SETTLE_CYC = 8
) (
  input wire logic        ref_clk,
  input wire logic        sys_rst,
  input wire logic        calRequest,
  input wire logic        cal_select_a,
  input wire logic        cal_select_b,
  input wire logic        conversion_valid_n,
  input wire logic [19:0] dataCode,
  input wire logic        calBusy
);
  logic [15:0] cnt_r;
  logic [1:0]  mode_r;
  // Cycles since request fell; mode as the design should have latched it
  always_ff @(posedge ref_clk) begin
    cnt_r <= $fell(calRequest) ? 16'h0000 : cnt_r + 16'h0001;
    if ($rose(calRequest) && !calBusy)
      mode_r <= {cal_select_a, cal_select_b};
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  a_busy_on_rise: assert property ($rose(calRequest) && !calBusy |=> calBusy)
    else $error("request rise not taken");
  a_valid_busy: assert property (calBusy |-> conversion_valid_n)
    else $error("data ready low while busy");
  a_start_fall: assert property ($fell(calRequest) && calBusy
    |=> conversion_valid_n [*8]) else $error("data ready fell early");
  a_zero_load: assert property ($fell(conversion_valid_n) && mode_r[1]
    |-> dataCode == 20'h00000) else $error("zero scale code wrong");
  a_ones_load: assert property ($fell(conversion_valid_n) && mode_r == 2'b01
    |-> dataCode == 20'hFFFFF) else $error("full scale code wrong");
  a_self_time: assert property ($fell(conversion_valid_n) && mode_r == 2'b00
    |-> cnt_r inside {[SELF_CYC+SETTLE_CYC-1:SELF_CYC+SETTLE_CYC+3]})
    else $error("self calibration length wrong");
  a_sysoff_time: assert property ($fell(conversion_valid_n) && mode_r == 2'b11
    |-> cnt_r inside {[SYSOFF_CYC-1:SYSOFF_CYC+3]})
    else $error("system offset length wrong");
  a_sysgn_time: assert property ($fell(conversion_valid_n) && mode_r == 2'b01
    |-> cnt_r inside {[SYSGN_CYC-1:SYSGN_CYC+3]})
    else $error("system gain length wrong");
  a_oneoff_time: assert property ($fell(conversion_valid_n) && mode_r == 2'b10
    |-> cnt_r inside {[ONEOFF_CYC-1:ONEOFF_CYC+3]})
    else $error("one step offset length wrong");
endmodule
bind adc_calibration_sequencer adc_cal_properties #(.SELF_CYC(SELF_CYC),
  .SYSOFF_CYC(SYSOFF_CYC), .SYSGN_CYC(SYSGN_CYC), .ONEOFF_CYC(ONEOFF_CYC),
  .SETTLE_CYC(SETTLE_CYC)) adc_cal_properties_inst (.ref_clk(ref_clk),
  .sys_rst(sys_rst), .calRequest(calRequest), .cal_select_a(cal_select_a),
  .cal_select_b(cal_select_b), .conversion_valid_n(conversion_valid_n),
  .dataCode(dataCode), .calBusy(calBusy));
`default_nettype wire

/* testbench/cal_host_model.sv */
// Host driving the calibrate request and mode selects
`timescale 1ns/1ps
`default_nettype none
module cal_host_model (
  input  wire logic       ref_clk,
  input  wire logic       go,
  input  wire logic [1:0] mode,
  input  wire logic [3:0] hold,
  output logic            calRequest,
  output logic            cal_select_a,
  output logic            cal_select_b,
  output logic            done
);
  initial begin
    {calRequest, cal_select_a, cal_select_b, done} = 4'h0;
    forever begin
      @(posedge ref_clk);
      if (go) begin
        {cal_select_a, cal_select_b} <= mode;
        @(posedge ref_clk);
        calRequest <= 1'b1;
        repeat (hold) @(posedge ref_clk);
        calRequest <= 1'b0;
        // Flipped selects must be ignored by the running step
        {cal_select_a, cal_select_b} <= ~mode;
        done <= 1'b1;
        @(posedge ref_clk);
        done <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

/* testbench/tb_adc_calibration_sequencer.sv */
// Testbench for the calibration sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_adc_calibration_sequencer;
  logic        ref_clk = 1'b0, sys_rst = 1'b1, go = 1'b0;
  logic [1:0]  mode = 2'b00;
  logic [3:0]  hold = 4'h4;
  logic        calRequest, selA, selB, done, validN, busy;
  logic [19:0] code;
  logic        polSel = 1'b0, rawValid = 1'b0;
  logic [23:0] rawSample = 24'h000000;
  logic [1:0]  ord [4] = '{2'b11, 2'b01, 2'b10, 2'b00};
  localparam int LEN [4] = '{38, 24, 40, 20};
  int          bad_count = 0, total_checks = 0, n, k;
  always #20 ref_clk = ~ref_clk;
  // Short counts keep the run brief
  adc_calibration_sequencer #(.SELF_CYC(30), .SYSOFF_CYC(20),
    .SYSGN_CYC(24), .ONEOFF_CYC(40), .SETTLE_CYC(8))
    adc_calibration_sequencer_inst (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .calRequest(calRequest), .cal_select_a(selA), .cal_select_b(selB),
    .polarity_select(polSel), .rawSample(rawSample), .rawValid(rawValid),
    .conversion_valid_n(validN), .dataCode(code), .calBusy(busy));
  cal_host_model cal_host_model_inst (.ref_clk(ref_clk), .go(go),
    .mode(mode), .hold(hold), .calRequest(calRequest),
    .cal_select_a(selA), .cal_select_b(selB), .done(done));
  task automatic check(input string name, input logic [19:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s exp %h seen %h", name, exp, seen);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // One raw reading through the idle path; zero is 0, span 2^20 after self-cal
  task automatic measure(input logic [23:0] r, input logic p,
                         input logic [19:0] exp);
    @(posedge ref_clk);
    rawSample <= r;
    polSel    <= p;
    rawValid  <= 1'b1;
    @(posedge ref_clk);
    rawValid  <= 1'b0;
    @(negedge ref_clk);
    check("scaled", code, exp);
  endtask
  task automatic calibrate(input logic [1:0] m, input logic [3:0] h);
    int i;
    @(posedge ref_clk);
    mode <= m;
    hold <= h;
    go <= 1'b1;
    @(posedge ref_clk);
    go <= 1'b0;
    for (i = 0; i < 40 && done !== 1'b1; i++) @(posedge ref_clk);
    if (i == 40) begin
      bad_count++;
      print_verdict();
    end
    n = 0;
    while (n < 200 && validN !== 1'b0) begin
      @(negedge ref_clk);
      n++;
    end
  endtask
  initial begin
    repeat (5) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(negedge ref_clk);
    check("ready", validN, 1'b1);
    check("code", code, 20'h00000);
    // System offset step goes before system gain step
    for (k = 0; k < 4; k++) begin
      calibrate(ord[k], 4'h4);
      check("length", n >= LEN[ord[k]] - 1 && n <= LEN[ord[k]] + 3, 1'b1);
      if (ord[k] != 2'b00)
        check("code", code, ord[k] == 2'b01 ? 20'hFFFFF : 20'h00000);
      check("busy", busy, 1'b0);
    end
    // Data ready already low after self-cal, so no false fall here
    measure(24'h080000, 1'b0, 20'h80000);
    measure(24'h080000, 1'b1, 20'hC0000);
    measure(24'h100000, 1'b0, 20'hFFFFF);
    check("ready", validN, 1'b0);
    measure(24'h000000, 1'b0, 20'h00000);
    calibrate(2'b11, 4'h3);
    check("refused", 20'(n), 20'd200);
    check("busy", busy, 1'b0);
    print_verdict();
  end
endmodule
`default_nettype wire
